// File: inc/pipl_pkg.sv
// package for the low-bank port intensity pwm block: register map, field
// layout, reset values, request carrier and state layout.
// assumes one clock domain shared with the serial slave that issues requests.
package pipl_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NIB_W = 4;
   localparam int PORTS = 8;
   localparam int REGS = 4;
   localparam int IDX_W = 2;
   localparam logic [ADDR_W-1:0] ADDR_PIN1_PIN0 = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_PIN3_PIN2 = 8'h11;
   localparam logic [ADDR_W-1:0] ADDR_PIN5_PIN4 = 8'h12;
   localparam logic [ADDR_W-1:0] ADDR_PIN7_PIN6 = 8'h13;
   localparam logic [ADDR_W-1:0] INTENS_BASE = ADDR_PIN1_PIN0;
   localparam logic [ADDR_W-1:0] INTENS_MASK = 8'hfc;

   // ---------------------------------------------------------------
   // field layout and codes
   // ---------------------------------------------------------------
   localparam int NIB_HI_MSB = 7;
   localparam int NIB_HI_LSB = 4;
   localparam int NIB_LO_MSB = 3;
   localparam int NIB_LO_LSB = 0;
   localparam logic [NIB_W-1:0] NIB_STATIC = 4'hf;
   localparam logic [NIB_W-1:0] MASTER_OFF = 4'h0;
   localparam logic [NIB_W-1:0] SLOT_STEP = 4'h1;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;
   localparam logic [DATA_W-1:0] INTENS_RESET = 8'hff;
   localparam logic [DATA_W-1:0] UNMAPPED_DATA = 8'h00;

   // ---------------------------------------------------------------
   // carriers and state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic rw;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pipl_req_t;

   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] data;
   } pipl_rsp_t;

   typedef struct packed {
      logic [REGS-1:0][DATA_W-1:0] regs;
      logic [NIB_W-1:0] slot;
      pipl_rsp_t rsp;
   } pipl_state_t;

   localparam pipl_state_t STATE_RESET = '{
      regs: {REGS{INTENS_RESET}},
      slot: MASTER_OFF,
      rsp: '{valid: 1'b0, data: UNMAPPED_DATA}
   };

   typedef struct packed {
      logic on;
   } pipl_port_state_t;

endpackage

// File: hdl/pipl_port_pwm.sv
// one port's pwm output stage: compares the shared slot against the nibble.
// assumes the slot counter and nibble come from the same clock domain.
`timescale 1ns/1ps
module pipl_port_pwm (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic [pipl_pkg::NIB_W-1:0] nibble,
   input wire logic [pipl_pkg::NIB_W-1:0] slot,
   input wire logic halt,
   // port drive, high while the port is on
   output logic on
);

   pipl_pkg::pipl_port_state_t st_reg;
   pipl_pkg::pipl_port_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (halt) begin
         // oscillator stopped: static level, no modulation
         st_next.on = 1'b1;
      end else if (nibble == pipl_pkg::NIB_STATIC) begin
         st_next.on = 1'b1;
      end else begin
         // nibble+1 slots on out of sixteen
         st_next.on = (slot <= nibble);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '{on: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign on = st_reg.on;

endmodule

// File: hdl/pipl_top.sv
// intensity registers and pwm generation for output ports 0 to 7.
// assumes the serial slave decodes the frame and presents one request per
// cycle on the same clock; the master intensity field comes from elsewhere.
`timescale 1ns/1ps

module pipl_top (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // register requests from the serial slave
   input wire pipl_pkg::pipl_req_t REG_REQ,
   output pipl_pkg::pipl_rsp_t REG_RSP,
   // master intensity field, held elsewhere
   input wire logic [pipl_pkg::NIB_W-1:0] MASTER_LEVEL,
   // port drive, high while a port is on
   output logic [pipl_pkg::PORTS-1:0] PORT_ON
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   pipl_pkg::pipl_state_t st_reg;
   pipl_pkg::pipl_state_t st_next;
   logic hit;
   logic [pipl_pkg::IDX_W-1:0] idx;
   logic halt;
   logic [pipl_pkg::PORTS-1:0][pipl_pkg::NIB_W-1:0] nib;

   assign hit = (REG_REQ.addr & pipl_pkg::INTENS_MASK) == pipl_pkg::INTENS_BASE;
   assign idx = REG_REQ.addr[pipl_pkg::IDX_W-1:0];
   assign halt = (MASTER_LEVEL == pipl_pkg::MASTER_OFF);

   // ---------------------------------------------------------------
   // nibble split: odd port in the upper half, even port in the lower
   // ---------------------------------------------------------------
   genvar r;
   generate
      for (r = 0; r < pipl_pkg::REGS; r++) begin : g_split
         assign nib[2*r+1] = st_reg.regs[r][pipl_pkg::NIB_HI_MSB:pipl_pkg::NIB_HI_LSB];
         assign nib[2*r] = st_reg.regs[r][pipl_pkg::NIB_LO_MSB:pipl_pkg::NIB_LO_LSB];
      end
   endgenerate

   // ---------------------------------------------------------------
   // register access and slot counter
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.rsp.valid = 1'b0;
      if (REG_REQ.valid) begin
         if (REG_REQ.rw == pipl_pkg::RW_WRITE) begin
            // unmapped writes are dropped silently
            if (hit) begin
               st_next.regs[idx] = REG_REQ.wdata;
            end
         end else begin
            st_next.rsp.valid = 1'b1;
            // unmapped reads answer zero so the slave always gets a byte
            st_next.rsp.data = hit ? st_reg.regs[idx] : pipl_pkg::UNMAPPED_DATA;
         end
      end
      // the counter freezes while the oscillator is stopped
      if (!halt) begin
         st_next.slot = st_reg.slot + pipl_pkg::SLOT_STEP;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         st_reg <= pipl_pkg::STATE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign REG_RSP = st_reg.rsp;

   // ---------------------------------------------------------------
   // per-port output stages
   // ---------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < pipl_pkg::PORTS; p++) begin : g_port
         pipl_port_pwm u_pwm (
            .clk(MCLK),
            .rst(RST),
            .nibble(nib[p]),
            .slot(st_reg.slot),
            .halt(halt),
            .on(PORT_ON[p])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);

   // write-data nibbles, so the field checks name no bit positions
   logic [pipl_pkg::NIB_W-1:0] wr_hi;
   logic [pipl_pkg::NIB_W-1:0] wr_lo;
   assign wr_hi = REG_REQ.wdata[pipl_pkg::NIB_HI_MSB:pipl_pkg::NIB_HI_LSB];
   assign wr_lo = REG_REQ.wdata[pipl_pkg::NIB_LO_MSB:pipl_pkg::NIB_LO_LSB];

   sequence write_0x10;
      REG_REQ.valid && REG_REQ.rw == pipl_pkg::RW_WRITE
         && REG_REQ.addr == pipl_pkg::ADDR_PIN1_PIN0;
   endsequence

   sequence read_same;
      REG_REQ.valid && REG_REQ.rw == pipl_pkg::RW_READ
         && REG_REQ.addr == $past(REG_REQ.addr);
   endsequence

   sequence read_req;
      REG_REQ.valid && REG_REQ.rw == pipl_pkg::RW_READ;
   endsequence

   // misses are written from the map ends, not from the decoder, so a bad mask shows
   sequence read_miss;
      REG_REQ.valid && REG_REQ.rw == pipl_pkg::RW_READ
         && (REG_REQ.addr < pipl_pkg::ADDR_PIN1_PIN0
         || REG_REQ.addr > pipl_pkg::ADDR_PIN7_PIN6);
   endsequence

   sequence write_miss;
      REG_REQ.valid && REG_REQ.rw == pipl_pkg::RW_WRITE
         && (REG_REQ.addr < pipl_pkg::ADDR_PIN1_PIN0
         || REG_REQ.addr > pipl_pkg::ADDR_PIN7_PIN6);
   endsequence

   port1_field_a: assert property (write_0x10 |=>
      nib[1] == $past(wr_hi) && nib[0] == $past(wr_lo))
      else $error("port 1/0 nibbles not taken from the written byte");

   field_p3p2_a: assert property (REG_REQ.valid
      && REG_REQ.rw == pipl_pkg::RW_WRITE && REG_REQ.addr == pipl_pkg::ADDR_PIN3_PIN2
      |=> nib[3] == $past(wr_hi) && nib[2] == $past(wr_lo))
      else $error("port 3/2 nibbles not taken from the written byte");

   field_p5p4_a: assert property (REG_REQ.valid
      && REG_REQ.rw == pipl_pkg::RW_WRITE && REG_REQ.addr == pipl_pkg::ADDR_PIN5_PIN4
      |=> nib[5] == $past(wr_hi) && nib[4] == $past(wr_lo))
      else $error("port 5/4 nibbles not taken from the written byte");

   field_p7p6_a: assert property (REG_REQ.valid
      && REG_REQ.rw == pipl_pkg::RW_WRITE && REG_REQ.addr == pipl_pkg::ADDR_PIN7_PIN6
      |=> nib[7] == $past(wr_hi) && nib[6] == $past(wr_lo))
      else $error("port 7/6 nibbles not taken from the written byte");

   readback_a: assert property (write_0x10 ##1 read_same |=>
      REG_RSP.valid && REG_RSP.data == $past(REG_REQ.wdata, 2))
      else $error("read back differs from last write");

   read_answer_a: assert property (read_req |=> REG_RSP.valid)
      else $error("read request got no answer strobe");

   rsp_quiet_a: assert property (
      !(REG_REQ.valid && REG_REQ.rw == pipl_pkg::RW_READ) |=> !REG_RSP.valid)
      else $error("answer strobe without a read request");

   rsp_hold_a: assert property (
      !(REG_REQ.valid && REG_REQ.rw == pipl_pkg::RW_READ) |=> $stable(REG_RSP.data))
      else $error("read data moved without a read request");

   unmapped_read_a: assert property (read_miss |=>
      REG_RSP.data == pipl_pkg::UNMAPPED_DATA)
      else $error("unmapped read did not answer the fill byte");

   unmapped_write_a: assert property (write_miss |=> $stable(st_reg.regs))
      else $error("unmapped write changed an intensity register");

   duty_p0_a: assert property (!halt && nib[0] != pipl_pkg::NIB_STATIC |=>
      PORT_ON[0] == ($past(st_reg.slot) <= $past(nib[0])))
      else $error("port 0 duty does not follow its nibble");

   duty_p1_a: assert property (!halt && nib[1] != pipl_pkg::NIB_STATIC |=>
      PORT_ON[1] == ($past(st_reg.slot)
         <= $past(st_reg.regs[0][pipl_pkg::NIB_HI_MSB:pipl_pkg::NIB_HI_LSB])))
      else $error("port 1 does not follow the high nibble at 0x10");

   duty_p2_a: assert property (!halt && nib[2] != pipl_pkg::NIB_STATIC |=>
      PORT_ON[2] == ($past(st_reg.slot)
         <= $past(st_reg.regs[1][pipl_pkg::NIB_LO_MSB:pipl_pkg::NIB_LO_LSB])))
      else $error("port 2 does not follow the low nibble at 0x11");

   duty_p3_a: assert property (!halt && nib[3] != pipl_pkg::NIB_STATIC |=>
      PORT_ON[3] == ($past(st_reg.slot)
         <= $past(st_reg.regs[1][pipl_pkg::NIB_HI_MSB:pipl_pkg::NIB_HI_LSB])))
      else $error("port 3 does not follow the high nibble at 0x11");

   duty_p4_a: assert property (!halt && nib[4] != pipl_pkg::NIB_STATIC |=>
      PORT_ON[4] == ($past(st_reg.slot)
         <= $past(st_reg.regs[2][pipl_pkg::NIB_LO_MSB:pipl_pkg::NIB_LO_LSB])))
      else $error("port 4 does not follow the low nibble at 0x12");

   duty_p5_a: assert property (!halt && nib[5] != pipl_pkg::NIB_STATIC |=>
      PORT_ON[5] == ($past(st_reg.slot)
         <= $past(st_reg.regs[2][pipl_pkg::NIB_HI_MSB:pipl_pkg::NIB_HI_LSB])))
      else $error("port 5 does not follow the high nibble at 0x12");

   duty_p6_a: assert property (!halt && nib[6] != pipl_pkg::NIB_STATIC |=>
      PORT_ON[6] == ($past(st_reg.slot)
         <= $past(st_reg.regs[3][pipl_pkg::NIB_LO_MSB:pipl_pkg::NIB_LO_LSB])))
      else $error("port 6 does not follow the low nibble at 0x13");

   duty_p7_a: assert property (!halt && nib[7] != pipl_pkg::NIB_STATIC |=>
      PORT_ON[7] == ($past(st_reg.slot)
         <= $past(st_reg.regs[3][pipl_pkg::NIB_HI_MSB:pipl_pkg::NIB_HI_LSB])))
      else $error("port 7 does not follow the high nibble at 0x13");

   static_p1_a: assert property (!halt && nib[1] == pipl_pkg::NIB_STATIC |=>
      PORT_ON[1])
      else $error("all-ones nibble did not give a static level");

   halt_static_a: assert property (halt [*2] |-> &PORT_ON && $stable(st_reg.slot))
      else $error("outputs or counter moved with master intensity zero");

   slot_run_a: assert property (!halt |=>
      st_reg.slot == $past(st_reg.slot) + pipl_pkg::SLOT_STEP)
      else $error("slot counter did not advance by one");

endmodule

// File: test/pipl_master.sv
// bus master model: issues register requests one at a time.
// assumes requests are taken on the rising clock edge.
`timescale 1ns/1ps
module pipl_master (
   // clock
   input wire logic clk,
   // request and answer
   output pipl_pkg::pipl_req_t req,
   input wire pipl_pkg::pipl_rsp_t rsp
);
   initial begin
      req = '0;
   end

   // released fields carry the inverse so a stale value cannot pass
   task automatic put(input logic rw, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{valid: 1'b1, rw: rw, addr: a, wdata: d};
      @(posedge clk);
      req <= '{valid: 1'b0, rw: ~rw, addr: ~a, wdata: ~d};
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      put(pipl_pkg::RW_WRITE, a, d);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      put(pipl_pkg::RW_READ, a, 8'h00);
      #1;
      v = rsp.valid;
      d = rsp.data;
   endtask

   // write then read the same word on the next edge, strobe held high between them
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
         output logic v);
      @(posedge clk);
      req <= '{valid: 1'b1, rw: pipl_pkg::RW_WRITE, addr: a, wdata: d};
      @(posedge clk);
      req <= '{valid: 1'b1, rw: pipl_pkg::RW_READ, addr: a, wdata: ~d};
      @(posedge clk);
      req <= '{valid: 1'b0, rw: pipl_pkg::RW_WRITE, addr: ~a, wdata: d};
      #1;
      v = rsp.valid;
      q = rsp.data;
   endtask
endmodule

// File: test/pipl_top_tb.sv
// testbench for the low-bank intensity registers and pwm outputs.
// assumes a one-cycle read answer and one pwm slot per clock.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module pipl_top_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] master_level = 4'h5;
   pipl_pkg::pipl_req_t reg_req;
   pipl_pkg::pipl_rsp_t reg_rsp;
   logic [7:0] port_on;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [7:0] rdata;
   logic rvalid;
   logic [4:0] cnt [8];

   always #2.5 mclk = ~mclk;

   pipl_top u_pipl_top (.MCLK(mclk), .RST(rst), .REG_REQ(reg_req), .REG_RSP(reg_rsp),
      .MASTER_LEVEL(master_level), .PORT_ON(port_on));
   pipl_master u_pipl_master (.clk(mclk), .req(reg_req), .rsp(reg_rsp));

   // ---------------------------------------------------------------
   // closing report and hang guard
   // ---------------------------------------------------------------
   task automatic tally_and_finish();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   // on-slot count over one full 16-cycle period per port
   task automatic count16();
      for (int k = 0; k < 8; k++) cnt[k] = '0;
      repeat (16) begin
         @(posedge mclk);
         #1;
         for (int k = 0; k < 8; k++) cnt[k] = cnt[k] + 5'(port_on[k]);
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      #1;
      `CHK("port_on reset", 8'hff, port_on)
      for (int i = 0; i < 4; i++) begin
         u_pipl_master.rd(8'h10 + 8'(i), rdata, rvalid);
         `CHK("reset value", 8'hff, rdata)
      end
      // two rounds set every nibble code once; port k gets code 8*r+k
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 4; i++)
            u_pipl_master.wr(8'h10 + 8'(i), {4'(8*r+2*i+1), 4'(8*r+2*i)});
         u_pipl_master.wr(8'h14, 8'h00);
         for (int i = 0; i < 4; i++) begin
            u_pipl_master.rd(8'h10 + 8'(i), rdata, rvalid);
            `CHK("readback", {4'(8*r+2*i+1), 4'(8*r+2*i)}, rdata)
            `CHK("read answer", 1'b1, rvalid)
         end
         count16();
         for (int k = 0; k < 8; k++)
            `CHK("duty slots", 5'(8*r+k+1), cnt[k])
      end
      u_pipl_master.rd(8'h17, rdata, rvalid);
      `CHK("unmapped read", 8'h00, rdata)
      `CHK("unmapped answer", 1'b1, rvalid)
      // write and read on adjacent edges: the read must already see the new byte
      u_pipl_master.wr_rd(8'h10, 8'h5c, rdata, rvalid);
      `CHK("write-read", 8'h5c, rdata)
      `CHK("write-read answer", 1'b1, rvalid)
      // low nibbles again, then master zero must force every port static
      u_pipl_master.wr(8'h10, 8'h10);
      @(posedge mclk);
      master_level <= 4'h0;
      repeat (2) @(posedge mclk);
      count16();
      for (int k = 0; k < 8; k++)
         `CHK("static slots", 5'd16, cnt[k])
      tally_and_finish();
   end
endmodule
